// *** src/gpe_cfg.svh ***
// Purpose: Constants for the 1000BASE-X PCS framing block.
// Assumes: One code group per clock, 8-bit code group plus K flag.
// Notes:   Code-group values are the decoded 8-bit form (before 8B/10B).
//
// Functional notes
// - Configuration sets alternate, four groups each
// - Idles: comma then correcting or preserving data
// - Delimiters: extend, start, end, error codes
// - Idle comma even slot, data odd
// - Even start: start replaces first preamble byte
// - Odd start: idle completion, then start
// - Receiver restores preamble byte for start
// - Preamble byte lost at odd start not regenerated
// - End code immediately after enable falls
// - Slot alignment kept through whole frame
// - Even end: one carrier extend follows
// - Odd end: two carrier extends follow
// - First idle picked by running disparity
// - End plus two extends: error, 0x0F
// - Stream via serial or ten-bit interface
`ifndef GPE_CFG_SVH
`define GPE_CFG_SVH

// ----------------------------------------------------------------------
// Code groups
// ----------------------------------------------------------------------
`define GPE_K28_5        8'hBC
`define GPE_D21_5        8'hB5
`define GPE_D2_2         8'h42
`define GPE_D5_6         8'hC5
`define GPE_D16_2        8'h50
`define GPE_K23_7        8'hF7
`define GPE_K27_7        8'hFB
`define GPE_K29_7        8'hFD
`define GPE_K30_7        8'hFE

// ----------------------------------------------------------------------
// GMII values and sequence counts
// ----------------------------------------------------------------------
`define GPE_PREAMBLE     8'h55
`define GPE_FRAME_EXT    8'h0F
`define GPE_ZERO_BYTE    8'h00
`define GPE_CFG_FIRST    2'h0
`define GPE_CFG_SECOND   2'h1
`define GPE_CFG_THIRD    2'h2
`define GPE_CFG_LAST     2'h3
`define GPE_CFG_STEP     2'h1

`endif

// *** src/gpe_pkg.sv ***
// Purpose: Types shared by the PCS framing modules.
// Assumes: Nothing beyond the configuration header.
// Notes:   State encodings are left to the tools.
package gpe_pkg;

   typedef enum logic [2:0] {
      GPE_TX_IDLE,
      GPE_TX_SOP,
      GPE_TX_DATA,
      GPE_TX_EXT2,
      GPE_TX_EXT1,
      GPE_TX_CFG
   } gpe_tx_state_t;

   typedef enum logic [1:0] {
      GPE_RX_IDLE,
      GPE_RX_DATA,
      GPE_RX_TERM,
      GPE_RX_TERM_EXT
   } gpe_rx_state_t;

endpackage : gpe_pkg

// *** src/gpe_cg_match.sv ***
// Purpose: Detects one fixed code group on the receive stream.
// Assumes: Code group and K flag arrive on the block clock.
// Notes:   Purely combinational.
`timescale 1ns/10ps
module gpe_cg_match
   import gpe_pkg::*;
#(
   parameter logic [7:0] MATCH_CG = 8'h00,
   parameter logic       MATCH_K  = 1'b1
) (
   input  wire logic [7:0] i_cg,
   input  wire logic       i_k,
   output logic            o_hit
);
   assign o_hit = (i_cg == MATCH_CG) && (i_k == MATCH_K);
endmodule : gpe_cg_match

// *** src/gpe_cfg_seq.sv ***
// Purpose: Picks one code group of a configuration ordered set.
// Assumes: Index walks 0..3 inside one set.
// Notes:   Variant flag selects the first or second configuration set.
`timescale 1ns/10ps
`include "gpe_cfg.svh"
module gpe_cfg_seq
   import gpe_pkg::*;
(
   input  wire logic [1:0]  i_idx,
   input  wire logic        i_second,
   input  wire logic [15:0] i_word,
   output logic [7:0]       o_cg,
   output logic             o_k
);
   always_comb begin
      o_k  = 1'b0;
      o_cg = i_word[15:8];
      if (i_idx == `GPE_CFG_FIRST) begin
         o_cg = `GPE_K28_5;
         o_k  = 1'b1;
      end else if (i_idx == `GPE_CFG_SECOND) begin
         o_cg = i_second ? `GPE_D2_2 : `GPE_D21_5;
      end else if (i_idx == `GPE_CFG_THIRD) begin
         o_cg = i_word[7:0];
      end
   end
endmodule : gpe_cfg_seq

// *** src/gpe_pcs_frame_encap.sv ***
// Purpose: 1000BASE-X PCS framing: GMII to code groups and back.
// Assumes: One code group per i_clk; line logic on the same clock.
// Notes:   8B/10B coding lies outside; running disparity comes in.
`timescale 1ns/10ps
`include "gpe_cfg.svh"
module gpe_pcs_frame_encap
   import gpe_pkg::*;
#(
   parameter int CG_W = 8
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic [7:0]  i_gmii_txd,
   input  wire logic        i_gmii_tx_en,
   input  wire logic        i_gmii_tx_er,
   input  wire logic        i_cfg_send,
   input  wire logic [15:0] i_cfg_word,
   input  wire logic        i_tx_rd_pos,
   input  wire logic        i_use_tbi,
   output logic [7:0]       o_ser_tx_cg,
   output logic             o_ser_tx_k,
   output logic [7:0]       o_tbi_tx_cg,
   output logic             o_tbi_tx_k,
   output logic             o_tx_odd,
   input  wire logic [7:0]  i_ser_rx_cg,
   input  wire logic        i_ser_rx_k,
   input  wire logic [7:0]  i_tbi_rx_cg,
   input  wire logic        i_tbi_rx_k,
   output logic [7:0]       o_gmii_rxd,
   output logic             o_gmii_rx_dv,
   output logic             o_gmii_rx_er
);

   // ----------------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------------
   if (CG_W != 8) begin : g_bad_width
      $error("gpe_pcs_frame_encap: CG_W must be 8");
   end

   // ----------------------------------------------------------------------
   // Transmit state
   // ----------------------------------------------------------------------
   gpe_tx_state_t tx_st_q;
   gpe_tx_state_t tx_st_d;
   logic          tx_odd_q;
   logic          tx_odd_d;
   logic          first_idle_q;
   logic          first_idle_d;
   logic [1:0]    cfg_idx_q;
   logic [1:0]    cfg_idx_d;
   logic          cfg_second_q;
   logic          cfg_second_d;
   logic [7:0]    tx_cg;
   logic          tx_k;
   logic [7:0]    ser_cg_q;
   logic [7:0]    ser_cg_d;
   logic          ser_k_q;
   logic          ser_k_d;
   logic [7:0]    tbi_cg_q;
   logic [7:0]    tbi_cg_d;
   logic          tbi_k_q;
   logic          tbi_k_d;
   logic          odd_out_q;
   logic [7:0]    cfg_cg;
   logic          cfg_k;

   gpe_cfg_seq u_cfg_seq (
      .i_idx    (cfg_idx_q),
      .i_second (cfg_second_q),
      .i_word   (i_cfg_word),
      .o_cg     (cfg_cg),
      .o_k      (cfg_k)
   );

   always_comb begin
      tx_st_d      = tx_st_q;
      first_idle_d = first_idle_q;
      cfg_idx_d    = cfg_idx_q;
      cfg_second_d = cfg_second_q;
      tx_cg        = `GPE_K28_5;
      tx_k         = 1'b1;
      tx_odd_d     = ~tx_odd_q;
      case (tx_st_q)
         GPE_TX_IDLE: begin
            if (!tx_odd_q) begin
               if (i_gmii_tx_en) begin
                  tx_cg   = `GPE_K27_7;
                  tx_st_d = GPE_TX_DATA;
               end else if (i_cfg_send) begin
                  tx_cg     = cfg_cg;
                  tx_k      = cfg_k;
                  cfg_idx_d = `GPE_CFG_SECOND;
                  tx_st_d   = GPE_TX_CFG;
               end else begin
                  tx_cg = `GPE_K28_5;
               end
            end else begin
               tx_k         = 1'b0;
               first_idle_d = 1'b0;
               if (first_idle_q && i_tx_rd_pos && !i_gmii_tx_en) begin
                  tx_cg = `GPE_D5_6;
               end else begin
                  tx_cg = `GPE_D16_2;
               end
               if (i_gmii_tx_en) begin
                  tx_st_d = GPE_TX_SOP;
               end
            end
         end
         GPE_TX_SOP: begin
            tx_cg   = `GPE_K27_7;
            tx_st_d = GPE_TX_DATA;
         end
         GPE_TX_DATA: begin
            if (i_gmii_tx_en) begin
               if (i_gmii_tx_er) begin
                  tx_cg = `GPE_K30_7;
               end else begin
                  tx_cg = i_gmii_txd;
                  tx_k  = 1'b0;
               end
            end else begin
               tx_cg = `GPE_K29_7;
               if (tx_odd_q) begin
                  tx_st_d = GPE_TX_EXT2;
               end else begin
                  tx_st_d = GPE_TX_EXT1;
               end
            end
         end
         GPE_TX_EXT2: begin
            tx_cg   = `GPE_K23_7;
            tx_st_d = GPE_TX_EXT1;
         end
         GPE_TX_EXT1: begin
            tx_cg        = `GPE_K23_7;
            first_idle_d = 1'b1;
            tx_st_d      = GPE_TX_IDLE;
         end
         GPE_TX_CFG: begin
            tx_cg     = cfg_cg;
            tx_k      = cfg_k;
            cfg_idx_d = cfg_idx_q + `GPE_CFG_STEP;
            if (cfg_idx_q == `GPE_CFG_LAST) begin
               cfg_idx_d    = `GPE_CFG_FIRST;
               cfg_second_d = ~cfg_second_q;
               tx_st_d      = GPE_TX_IDLE;
            end
         end
         default: begin
            tx_st_d = GPE_TX_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Line selection, transmit side
   // ----------------------------------------------------------------------
   // Unused port keeps sending comma so a listener stays aligned
   always_comb begin
      ser_cg_d = `GPE_K28_5;
      ser_k_d  = 1'b1;
      tbi_cg_d = `GPE_K28_5;
      tbi_k_d  = 1'b1;
      if (i_use_tbi) begin
         tbi_cg_d = tx_cg;
         tbi_k_d  = tx_k;
      end else begin
         ser_cg_d = tx_cg;
         ser_k_d  = tx_k;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_st_q      <= GPE_TX_IDLE;
         tx_odd_q     <= 1'b0;
         first_idle_q <= 1'b0;
         cfg_idx_q    <= `GPE_CFG_FIRST;
         cfg_second_q <= 1'b0;
         ser_cg_q     <= `GPE_K28_5;
         ser_k_q      <= 1'b1;
         tbi_cg_q     <= `GPE_K28_5;
         tbi_k_q      <= 1'b1;
         odd_out_q    <= 1'b1;
      end else begin
         tx_st_q      <= tx_st_d;
         tx_odd_q     <= tx_odd_d;
         first_idle_q <= first_idle_d;
         cfg_idx_q    <= cfg_idx_d;
         cfg_second_q <= cfg_second_d;
         ser_cg_q     <= ser_cg_d;
         ser_k_q      <= ser_k_d;
         tbi_cg_q     <= tbi_cg_d;
         tbi_k_q      <= tbi_k_d;
         odd_out_q    <= tx_odd_q;
      end
   end

   assign o_ser_tx_cg = ser_cg_q;
   assign o_ser_tx_k  = ser_k_q;
   assign o_tbi_tx_cg = tbi_cg_q;
   assign o_tbi_tx_k  = tbi_k_q;
   assign o_tx_odd    = odd_out_q;

   // ----------------------------------------------------------------------
   // Receive decode
   // ----------------------------------------------------------------------
   gpe_rx_state_t rx_st_q;
   gpe_rx_state_t rx_st_d;
   logic [7:0]    rx_cg;
   logic          rx_k;
   logic          hit_sop;
   logic          hit_eop;
   logic          hit_ext;
   logic          hit_err;
   logic [7:0]    rxd_q;
   logic [7:0]    rxd_d;
   logic          rx_dv_q;
   logic          rx_dv_d;
   logic          rx_er_q;
   logic          rx_er_d;

   assign rx_cg = i_use_tbi ? i_tbi_rx_cg : i_ser_rx_cg;
   assign rx_k  = i_use_tbi ? i_tbi_rx_k : i_ser_rx_k;

   gpe_cg_match #(.MATCH_CG(`GPE_K27_7), .MATCH_K(1'b1)) u_hit_sop (
      .i_cg  (rx_cg),
      .i_k   (rx_k),
      .o_hit (hit_sop)
   );
   gpe_cg_match #(.MATCH_CG(`GPE_K29_7), .MATCH_K(1'b1)) u_hit_eop (
      .i_cg  (rx_cg),
      .i_k   (rx_k),
      .o_hit (hit_eop)
   );
   gpe_cg_match #(.MATCH_CG(`GPE_K23_7), .MATCH_K(1'b1)) u_hit_ext (
      .i_cg  (rx_cg),
      .i_k   (rx_k),
      .o_hit (hit_ext)
   );
   gpe_cg_match #(.MATCH_CG(`GPE_K30_7), .MATCH_K(1'b1)) u_hit_err (
      .i_cg  (rx_cg),
      .i_k   (rx_k),
      .o_hit (hit_err)
   );

   always_comb begin
      rx_st_d = rx_st_q;
      rxd_d   = `GPE_ZERO_BYTE;
      rx_dv_d = 1'b0;
      rx_er_d = 1'b0;
      case (rx_st_q)
         GPE_RX_IDLE: begin
            if (hit_sop) begin
               rxd_d   = `GPE_PREAMBLE;
               rx_dv_d = 1'b1;
               rx_st_d = GPE_RX_DATA;
            end
         end
         GPE_RX_DATA: begin
            if (hit_eop) begin
               rx_st_d = GPE_RX_TERM;
            end else if (rx_k && !hit_err) begin
               // Unexpected control code ends the frame in error
               rx_er_d = 1'b1;
               rx_dv_d = 1'b1;
               rx_st_d = GPE_RX_IDLE;
            end else begin
               rxd_d   = rx_cg;
               rx_dv_d = 1'b1;
               rx_er_d = hit_err;
            end
         end
         GPE_RX_TERM: begin
            rx_st_d = hit_ext ? GPE_RX_TERM_EXT : GPE_RX_IDLE;
         end
         GPE_RX_TERM_EXT: begin
            if (hit_ext) begin
               rxd_d   = `GPE_FRAME_EXT;
               rx_er_d = 1'b1;
            end
            rx_st_d = GPE_RX_IDLE;
         end
         default: begin
            rx_st_d = GPE_RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_st_q <= GPE_RX_IDLE;
         rxd_q   <= `GPE_ZERO_BYTE;
         rx_dv_q <= 1'b0;
         rx_er_q <= 1'b0;
      end else begin
         rx_st_q <= rx_st_d;
         rxd_q   <= rxd_d;
         rx_dv_q <= rx_dv_d;
         rx_er_q <= rx_er_d;
      end
   end

   assign o_gmii_rxd   = rxd_q;
   assign o_gmii_rx_dv = rx_dv_q;
   assign o_gmii_rx_er = rx_er_q;

endmodule : gpe_pcs_frame_encap

// *** test/gpe_frame_monitor.sv ***
// Purpose: Concurrent checks on the PCS framing block ports.
// Assumes: Tx port choice follows i_use_tbi one edge late.
// Notes:   Checks start one edge after reset leaves.
`timescale 1ns/10ps
module gpe_frame_monitor (
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic       i_use_tbi,
   input wire logic       i_tx_rd_pos,
   input wire logic [7:0] o_ser_tx_cg,
   input wire logic       o_ser_tx_k,
   input wire logic [7:0] o_tbi_tx_cg,
   input wire logic       o_tbi_tx_k,
   input wire logic       o_tx_odd,
   input wire logic [7:0] i_ser_rx_cg,
   input wire logic       i_ser_rx_k,
   input wire logic [7:0] i_tbi_rx_cg,
   input wire logic       i_tbi_rx_k,
   input wire logic [7:0] o_gmii_rxd,
   input wire logic       o_gmii_rx_dv,
   input wire logic       o_gmii_rx_er
);
   logic       run_d, run_q, tbi_d, tbi_q, tk, rk;
   logic [7:0] tcg, rcg;
   // ------
   // Helpers
   // ------
   always_comb begin
      run_d = 1'b1;
      tbi_d = i_use_tbi;
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         run_q <= 1'b0;
         tbi_q <= 1'b0;
      end else begin
         run_q <= run_d;
         tbi_q <= tbi_d;
      end
   end
   assign tcg = tbi_q ? o_tbi_tx_cg : o_ser_tx_cg;
   assign tk  = tbi_q ? o_tbi_tx_k : o_ser_tx_k;
   assign rcg = i_use_tbi ? i_tbi_rx_cg : i_ser_rx_cg;
   assign rk  = i_use_tbi ? i_tbi_rx_k : i_ser_rx_k;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   unsel_ser_a: assert property (run_q && tbi_q |-> o_ser_tx_k && o_ser_tx_cg == 8'hBC)
      else $error("serial port busy while ten-bit port chosen");
   unsel_tbi_a: assert property (run_q && !tbi_q |-> o_tbi_tx_k && o_tbi_tx_cg == 8'hBC)
      else $error("ten-bit port busy while serial port chosen");
   comma_even_a: assert property (run_q && tk && tcg == 8'hBC |-> !o_tx_odd)
      else $error("comma in odd slot");
   slot_toggle_a: assert property (run_q |-> o_tx_odd != $past(o_tx_odd))
      else $error("slot parity did not alternate");
   sop_even_a: assert property (run_q && tk && tcg == 8'hFB |-> !o_tx_odd)
      else $error("start code in odd slot");
   ext_one_a: assert property (
      run_q && tk && tcg == 8'hFD && !o_tx_odd |=> tk && tcg == 8'hF7 ##1 tk && tcg == 8'hBC)
      else $error("even end not followed by one extend");
   ext_two_a: assert property (
      run_q && tk && tcg == 8'hFD && o_tx_odd |=> tk && tcg == 8'hF7 ##1 tk && tcg == 8'hF7
      ##1 tk && tcg == 8'hBC)
      else $error("odd end not followed by two extends");
   first_idle_a: assert property (
      (run_q && tk && tcg == 8'hF7 ##1 tk && tcg == 8'hBC)
      |=> !tk && tcg == ($past(i_tx_rd_pos) ? 8'hC5 : 8'h50))
      else $error("first idle variant wrong");
   later_idle_a: assert property (
      (run_q && tk && tcg == 8'hBC && !($past(tk) && $past(tcg) == 8'hF7))
      ##1 (!tk && tcg != 8'hB5 && tcg != 8'h42) |-> tcg == 8'h50)
      else $error("later idle not preserving");
   rx_sop_a: assert property (
      run_q && rk && rcg == 8'hFB && !o_gmii_rx_dv
      |=> o_gmii_rx_dv && !o_gmii_rx_er && o_gmii_rxd == 8'h55)
      else $error("start code not turned into preamble");
   rx_ext_a: assert property (
      (run_q && rk && rcg == 8'hFD ##1 rk && rcg == 8'hF7 ##1 rk && rcg == 8'hF7)
      |=> o_gmii_rx_er && !o_gmii_rx_dv && o_gmii_rxd == 8'h0F)
      else $error("frame extension not signalled");
endmodule : gpe_frame_monitor

bind gpe_pcs_frame_encap gpe_frame_monitor gpe_frame_monitor_i (
   .i_clk(i_clk), .i_rst(i_rst), .i_use_tbi(i_use_tbi), .i_tx_rd_pos(i_tx_rd_pos),
   .o_ser_tx_cg(o_ser_tx_cg), .o_ser_tx_k(o_ser_tx_k), .o_tbi_tx_cg(o_tbi_tx_cg),
   .o_tbi_tx_k(o_tbi_tx_k), .o_tx_odd(o_tx_odd), .i_ser_rx_cg(i_ser_rx_cg),
   .i_ser_rx_k(i_ser_rx_k), .i_tbi_rx_cg(i_tbi_rx_cg), .i_tbi_rx_k(i_tbi_rx_k),
   .o_gmii_rxd(o_gmii_rxd), .o_gmii_rx_dv(o_gmii_rx_dv), .o_gmii_rx_er(o_gmii_rx_er));

// *** test/gpe_line_loop.sv ***
// Purpose: Far PCS model: each line port echoes back after one group.
// Assumes: Both ports share i_clk.
// Notes:   Unused port echoes idle commas, so a wrong port shows no frames.
`timescale 1ns/10ps
module gpe_line_loop (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic [7:0] i_ser_cg,
   input  wire logic       i_ser_k,
   input  wire logic [7:0] i_tbi_cg,
   input  wire logic       i_tbi_k,
   output logic      [7:0] o_ser_cg,
   output logic            o_ser_k,
   output logic      [7:0] o_tbi_cg,
   output logic            o_tbi_k
);
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         {o_ser_k, o_ser_cg} <= 9'h1BC;
         {o_tbi_k, o_tbi_cg} <= 9'h1BC;
      end else begin
         {o_ser_k, o_ser_cg} <= {i_ser_k, i_ser_cg};
         {o_tbi_k, o_tbi_cg} <= {i_tbi_k, i_tbi_cg};
      end
   end
endmodule : gpe_line_loop

// *** test/gpe_pcs_frame_encap_tb.sv ***
// Purpose: Random frames and config sets through the framing block.
// Assumes: Line side looped back by the far model.
// Notes:   Expected streams are rebuilt from the bytes sent.
`timescale 1ns/10ps
module gpe_pcs_frame_encap_tb;
   logic        i_clk, i_rst, tx_en, tx_er, cfg_send, rd_pos, use_tbi, tx_odd;
   logic [7:0]  txd, ser_tx_cg, tbi_tx_cg, ser_rx_cg, tbi_rx_cg, rxd;
   logic        ser_tx_k, tbi_tx_k, ser_rx_k, tbi_rx_k, rx_dv, rx_er;
   logic [15:0] cfg_word;
   logic [8:0]  txq[$], rxq[$];
   logic [7:0]  b[16];
   logic [31:0] seed = 12;
   int          fail_count, checked, cyc, ext_n, fi;
   gpe_pcs_frame_encap gpe_pcs_frame_encap_i (.i_clk(i_clk), .i_rst(i_rst),
      .i_gmii_txd(txd), .i_gmii_tx_en(tx_en), .i_gmii_tx_er(tx_er), .i_cfg_send(cfg_send),
      .i_cfg_word(cfg_word), .i_tx_rd_pos(rd_pos), .i_use_tbi(use_tbi),
      .o_ser_tx_cg(ser_tx_cg), .o_ser_tx_k(ser_tx_k), .o_tbi_tx_cg(tbi_tx_cg),
      .o_tbi_tx_k(tbi_tx_k), .o_tx_odd(tx_odd), .i_ser_rx_cg(ser_rx_cg),
      .i_ser_rx_k(ser_rx_k), .i_tbi_rx_cg(tbi_rx_cg), .i_tbi_rx_k(tbi_rx_k),
      .o_gmii_rxd(rxd), .o_gmii_rx_dv(rx_dv), .o_gmii_rx_er(rx_er));
   gpe_line_loop gpe_line_loop_i (.i_clk(i_clk), .i_rst(i_rst), .i_ser_cg(ser_tx_cg),
      .i_ser_k(ser_tx_k), .i_tbi_cg(tbi_tx_cg), .i_tbi_k(tbi_tx_k), .o_ser_cg(ser_rx_cg),
      .o_ser_k(ser_rx_k), .o_tbi_cg(tbi_rx_cg), .o_tbi_k(tbi_rx_k));
   // ------
   // Helpers
   // ------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic int ext_cnt(input int np);
      return (np % 2 == 1) ? 1 : 2;
   endfunction : ext_cnt
   function automatic logic [8:0] exp_idle(input logic rd);
      return rd ? 9'h0C5 : 9'h050;
   endfunction : exp_idle
   task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report
   task automatic frame(input int par, input int len, input bit er_last);
      int k0, np, ne;
      txq.delete();
      rxq.delete();
      ext_n = 0;
      rd_pos = 1'(xs());
      for (int j = 0; j < len; j++) b[j] = 8'(xs());
      while (cyc % 2 != par) @(negedge i_clk);
      for (int j = 0; j < len; j++) begin
         tx_en = 1'b1;
         txd = b[j];
         tx_er = er_last && j == len - 1;
         @(negedge i_clk);
      end
      tx_en = 1'b0;
      tx_er = 1'b0;
      repeat (14) @(negedge i_clk);
      k0 = par + 1;
      np = len - k0;
      ne = ext_cnt(np);
      fi = -1;
      foreach (txq[i]) if (fi < 0 && txq[i] === 9'h1FB) fi = i;
      if (par == 1) chk("odd start fill", 9'h050, txq[fi - 1]);
      for (int j = 0; j < np; j++) begin
         chk("payload", (er_last && j == np - 1) ? 9'h1FE : {1'b0, b[k0 + j]}, txq[fi + 1 + j]);
         chk("rx data", (er_last && j == np - 1) ? 9'h100 : {1'b0, b[k0 + j]},
             (er_last && j == np - 1) ? rxq[j + 1] & 9'h100 : rxq[j + 1]);
      end
      chk("end code", 9'h1FD, txq[fi + 1 + np]);
      for (int j = 0; j < ne; j++) chk("extend", 9'h1F7, txq[fi + 2 + np + j]);
      chk("extend count", 9'h1BC, txq[fi + 2 + np + ne]);
      chk("first idle", exp_idle(rd_pos), txq[fi + 3 + np + ne]);
      chk("later idle", 9'h050, txq[fi + 5 + np + ne]);
      chk("rx preamble", 9'h055, rxq[0]);
      chk("rx bytes", 9'(np + 1), 9'(rxq.size()));
      chk("rx extension", 9'(ne == 2), 9'(ext_n));
   endtask : frame
   task automatic cfg_run();
      logic [8:0] e[8];
      cfg_word = 16'(xs());
      txq.delete();
      cfg_send = 1'b1;
      repeat (20) @(negedge i_clk);
      cfg_send = 1'b0;
      repeat (8) @(negedge i_clk);
      e = '{9'h1BC, 9'h0B5, {1'b0, cfg_word[7:0]}, {1'b0, cfg_word[15:8]},
            9'h1BC, 9'h042, {1'b0, cfg_word[7:0]}, {1'b0, cfg_word[15:8]}};
      fi = -1;
      foreach (txq[i]) if (fi < 0 && i > 0 && txq[i] === 9'h0B5 && txq[i - 1] === 9'h1BC) fi = i;
      for (int j = 0; j < 8; j++) chk("config", e[j], txq[fi - 1 + j]);
   endtask : cfg_run
   // ------
   // Clock, capture and sequence
   // ------
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) cyc <= 0;
      else cyc <= cyc + 1;
   end
   always @(negedge i_clk) begin
      txq.push_back(use_tbi ? {tbi_tx_k, tbi_tx_cg} : {ser_tx_k, ser_tx_cg});
      if (rx_dv === 1'b1) rxq.push_back({rx_er, rxd});
      else if (rx_er === 1'b1) ext_n++;
   end
   initial begin
      repeat (6000) @(posedge i_clk);
      fail_count++;
      final_report();
   end
   initial begin
      {i_rst, tx_en, tx_er, cfg_send, rd_pos, use_tbi} = 6'b10_0000;
      txd = 8'h00;
      cfg_word = 16'h0000;
      repeat (5) @(negedge i_clk);
      chk("reset idle", 9'h1BC, {ser_tx_k, ser_tx_cg});
      i_rst = 1'b0;
      repeat (4) @(negedge i_clk);
      cfg_run();
      i_rst = 1'b1;
      repeat (2) @(negedge i_clk);
      i_rst = 1'b0;
      frame(1, 3, 1'b1);
      for (int f = 0; f < 16; f++) begin
         use_tbi = f[2];
         repeat (3) @(negedge i_clk);
         frame(f % 2, 4 + f / 2 % 2 + 2 * int'(xs() % 3), f == 9);
      end
      final_report();
   end
endmodule : gpe_pcs_frame_encap_tb
